// [hdl/mdca_cfg.svh]
// constants for the dma channel arbiter: channel map, structure offsets, control word fields
`ifndef MDCA_CFG_SVH
`define MDCA_CFG_SVH
`define MDCA_CH_NUM 32
`define MDCA_CH_W 5
`define MDCA_PERIPH_MAP 32'h03c00f3f
`define MDCA_SW_CHANNEL 5'h1e
`define MDCA_ENTRY_SHIFT 4
`define MDCA_OFS_SRC 32'h00000000
`define MDCA_OFS_DST 32'h00000004
`define MDCA_OFS_CTL 32'h00000008
`define MDCA_CW_DINC_HI 31
`define MDCA_CW_DINC_LO 30
`define MDCA_CW_DSIZE_HI 29
`define MDCA_CW_DSIZE_LO 28
`define MDCA_CW_SINC_HI 27
`define MDCA_CW_SINC_LO 26
`define MDCA_CW_SSIZE_HI 25
`define MDCA_CW_SSIZE_LO 24
`define MDCA_CW_ARB_HI 23
`define MDCA_CW_ARB_LO 14
`define MDCA_CW_CNT_HI 13
`define MDCA_CW_CNT_LO 4
`define MDCA_CW_MODE_HI 2
`define MDCA_CW_MODE_LO 0
`define MDCA_CNT_W 10
`define MDCA_MODE_STOP 3'h0
`define MDCA_MODE_BASIC 3'h1
`define MDCA_MODE_AUTO 3'h2
`define MDCA_INC_NONE 2'h3
`define MDCA_RST_WORD 32'h00000000
`endif

// [hdl/mdca_pkg.sv]
// types for the dma channel arbiter
`include "mdca_cfg.svh"
package mdca_pkg;
  // main sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_FSRC, ST_FDST, ST_FCTL, ST_READ, ST_WRITE, ST_WBACK} mdca_fsm_t;
  // all state of the arbiter
  typedef struct packed {
    mdca_fsm_t st;
    logic [`MDCA_CH_NUM-1:0] chanEn;
    logic [`MDCA_CH_NUM-1:0] reqMask;
    logic [`MDCA_CH_NUM-1:0] prio;
    logic [`MDCA_CH_NUM-1:0] burstOnly;
    logic [`MDCA_CH_NUM-1:0] swPend;
    logic [`MDCA_CH_NUM-1:0] autoRun;
    logic [`MDCA_CH_NUM-1:0] doneIrq;
    logic [`MDCA_CH_W-1:0] grantCh;
    logic grantValid;
    logic isBurst;
    logic fin;
    logic access;
    logic busReq;
    logic busWrite;
    logic [31:0] busAddr;
    logic [31:0] busWdata;
    logic [1:0] busSize;
    logic [31:0] srcEnd;
    logic [31:0] dstEnd;
    logic [31:0] srcAddr;
    logic [31:0] dstAddr;
    logic [31:0] ctl;
    logic [`MDCA_CNT_W-1:0] remain;
    logic [`MDCA_CNT_W-1:0] burstLeft;
    logic [31:0] data;
  } mdca_regs_t;
endpackage

// [hdl/mdca_channel_arbiter.sv]
// dma channel arbiter and transfer sequencer for thirty-two channels
// Functional notes
// - thirty-two independent channels, 0 to 31
// - fixed peripheral request sources per channel
// - channel 30 and unassigned channels software only
// - lowest channel index wins within level
// - priority bit set beats every clear one
// - several high channels: lowest index wins
// - separate priority set and clear strobes
// - arbitrate over all pending channels
// - per channel burst size 1 to 1024
// - re-arbitrate after burst count moved
// - no preemption of a running burst
// - processor bus always wins, dma stalls
// - burst request wins when both asserted
// - item sizes 8, 16, 32 bits
// - per side address step or fixed
// - maskable requests, software request any channel
// - per channel completion pulse
// - parameters fetched from memory control table
// - single request in basic mode moves exactly one item
// - burst moves min of size and remainder
// - burst-only channel ignores single requests
`timescale 1ns/1ps
`default_nettype none
`include "mdca_cfg.svh"
module mdca_channel_arbiter
  import mdca_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] periphSingleReq,
  input wire logic [31:0] periphBurstReq,
  input wire logic [31:0] swReq,
  input wire logic [31:0] chanEnableSet,
  input wire logic [31:0] chanEnableClear,
  input wire logic [31:0] reqMaskSet,
  input wire logic [31:0] reqMaskClear,
  input wire logic [31:0] channelPrioritySetReg,
  input wire logic [31:0] channelPriorityClearReg,
  input wire logic [31:0] burstOnlySetReg,
  input wire logic [31:0] burstOnlyClearReg,
  input wire logic [21:0] tableBase,
  input wire logic cpuBusy,
  input wire logic busReady,
  input wire logic [31:0] busRdata,
  output logic busReq,
  output logic busWrite,
  output logic [31:0] busAddr,
  output logic [31:0] busWdata,
  output logic [1:0] busSize,
  output logic [31:0] chanDone,
  output logic [31:0] chanEnabled,
  output logic [31:0] chanPriority,
  output logic grantValid,
  output logic [4:0] grantCh
);

  // lowest set bit of a request vector
  function automatic logic [4:0] lowestIdx(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // address step per item, zero when the side is fixed
  function automatic logic [31:0] stepOf(input logic [1:0] inc);
    return (inc == `MDCA_INC_NONE) ? 32'h00000000 : (32'h00000001 << inc);
  endfunction

  // byte distance from first item to the inclusive end pointer
  function automatic logic [31:0] spanOf(input logic [9:0] n, input logic [1:0] inc);
    return (inc == `MDCA_INC_NONE) ? 32'h00000000 : ({22'h000000, n} << inc);
  endfunction

  mdca_regs_t s_q; // registered state
  mdca_regs_t s_d; // next state
  logic [31:0] perBurst; // usable burst requests
  logic [31:0] perSingle; // usable single requests
  logic [31:0] pend; // channels that may win
  logic [31:0] highPend; // pending at high level
  logic [4:0] winner; // arbitration result
  logic accepted; // bus took the access this cycle
  logic [31:0] entryBase; // control structure of granted channel
  logic [9:0] cwArb; // burst size minus one
  logic [9:0] cwCnt; // items left minus one
  logic [2:0] cwMode; // transfer mode
  // channels wired to a peripheral request line
  localparam logic [31:0] PERIPH_MAP = `MDCA_PERIPH_MAP;

  // request qualification and arbitration
  always_comb begin
    // only mapped channels see peripheral lines
    perBurst = periphBurstReq & `MDCA_PERIPH_MAP & ~s_q.reqMask;
    perSingle = periphSingleReq & `MDCA_PERIPH_MAP & ~s_q.reqMask & ~s_q.burstOnly;
    pend = s_q.chanEn & (perBurst | perSingle | s_q.swPend | s_q.autoRun);
    highPend = pend & s_q.prio;
    winner = (|highPend) ? lowestIdx(highPend) : lowestIdx(pend);
    accepted = s_q.busReq && busReady && !cpuBusy;
    entryBase = {tableBase, 10'h000} + {23'h000000, s_q.grantCh, 4'h0};
    cwArb = busRdata[`MDCA_CW_ARB_HI:`MDCA_CW_ARB_LO];
    cwCnt = busRdata[`MDCA_CW_CNT_HI:`MDCA_CW_CNT_LO];
    cwMode = busRdata[`MDCA_CW_MODE_HI:`MDCA_CW_MODE_LO];
  end

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.doneIrq = 32'h00000000;
    // set and clear strobes, set wins
    s_d.prio = (s_q.prio & ~channelPriorityClearReg) | channelPrioritySetReg;
    s_d.chanEn = (s_q.chanEn & ~chanEnableClear) | chanEnableSet;
    s_d.reqMask = (s_q.reqMask & ~reqMaskClear) | reqMaskSet;
    s_d.burstOnly = (s_q.burstOnly & ~burstOnlyClearReg) | burstOnlySetReg;
    // access drops once the bus took it
    if (accepted) begin
      s_d.access = 1'b0;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        // arbitrate only while idle, hold the grant
        if (|pend) begin
          s_d.grantCh = winner;
          s_d.grantValid = 1'b1;
          s_d.isBurst = perBurst[winner] | s_q.swPend[winner] | s_q.autoRun[winner];
          s_d.swPend[winner] = 1'b0;
          s_d.access = 1'b1;
          s_d.busWrite = 1'b0;
          s_d.busSize = 2'h2;
          s_d.busAddr = {tableBase, 10'h000} + {23'h000000, winner, 4'h0} + `MDCA_OFS_SRC;
          s_d.st = ST_FSRC;
        end
      end
      ST_FSRC: begin
        // source end pointer arrives
        if (accepted) begin
          s_d.srcEnd = busRdata;
          s_d.access = 1'b1;
          s_d.busAddr = entryBase + `MDCA_OFS_DST;
          s_d.st = ST_FDST;
        end
      end
      ST_FDST: begin
        // destination end pointer arrives
        if (accepted) begin
          s_d.dstEnd = busRdata;
          s_d.access = 1'b1;
          s_d.busAddr = entryBase + `MDCA_OFS_CTL;
          s_d.st = ST_FCTL;
        end
      end
      ST_FCTL: begin
        // control word arrives
        if (accepted) begin
          s_d.ctl = busRdata;
          if (cwMode == `MDCA_MODE_STOP) begin
            // stop mode disables the channel, a set strobe still wins
            s_d.chanEn[s_q.grantCh] = chanEnableSet[s_q.grantCh];
            s_d.autoRun[s_q.grantCh] = 1'b0;
            s_d.grantValid = 1'b0;
            s_d.st = ST_IDLE;
          end else begin
            // auto mode keeps the channel pending to the end
            if (cwMode == `MDCA_MODE_AUTO) begin
              s_d.autoRun[s_q.grantCh] = 1'b1;
            end
            s_d.remain = cwCnt;
            // burst moves min of size and remainder
            // burst size field holds size minus one
            if (s_q.isBurst || cwMode == `MDCA_MODE_AUTO) begin
              s_d.burstLeft = (cwArb < cwCnt) ? cwArb : cwCnt;
            end else begin
              s_d.burstLeft = 10'h000;
            end
            // first address from inclusive end pointer
            s_d.srcAddr = s_q.srcEnd - spanOf(cwCnt, busRdata[`MDCA_CW_SINC_HI:`MDCA_CW_SINC_LO]);
            s_d.dstAddr = s_q.dstEnd - spanOf(cwCnt, busRdata[`MDCA_CW_DINC_HI:`MDCA_CW_DINC_LO]);
            s_d.access = 1'b1;
            // item size drives the bus size
            s_d.busSize = busRdata[`MDCA_CW_SSIZE_HI:`MDCA_CW_SSIZE_LO];
            s_d.busAddr = s_q.srcEnd - spanOf(cwCnt, busRdata[`MDCA_CW_SINC_HI:`MDCA_CW_SINC_LO]);
            s_d.st = ST_READ;
          end
        end
      end
      ST_READ: begin
        // item read, now write it out
        if (accepted) begin
          s_d.data = busRdata;
          s_d.access = 1'b1;
          s_d.busWrite = 1'b1;
          s_d.busWdata = busRdata;
          s_d.busAddr = s_q.dstAddr;
          s_d.busSize = s_q.ctl[`MDCA_CW_DSIZE_HI:`MDCA_CW_DSIZE_LO];
          s_d.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        // item written, advance both sides
        if (accepted) begin
          s_d.srcAddr = s_q.srcAddr + stepOf(s_q.ctl[`MDCA_CW_SINC_HI:`MDCA_CW_SINC_LO]);
          s_d.dstAddr = s_q.dstAddr + stepOf(s_q.ctl[`MDCA_CW_DINC_HI:`MDCA_CW_DINC_LO]);
          s_d.access = 1'b1;
          if (s_q.remain == 10'h000 || s_q.burstLeft == 10'h000) begin
            // burst over, write back and re-arbitrate
            s_d.fin = (s_q.remain == 10'h000);
            s_d.ctl[`MDCA_CW_CNT_HI:`MDCA_CW_CNT_LO] = (s_q.remain == 10'h000) ? 10'h000 : s_q.remain - 10'h001;
            if (s_q.remain == 10'h000) begin
              s_d.ctl[`MDCA_CW_MODE_HI:`MDCA_CW_MODE_LO] = `MDCA_MODE_STOP;
              s_d.busWdata = {s_q.ctl[31:14], 10'h000, s_q.ctl[3], `MDCA_MODE_STOP};
            end else begin
              s_d.busWdata = {s_q.ctl[31:14], s_q.remain - 10'h001, s_q.ctl[3:0]};
            end
            s_d.busAddr = entryBase + `MDCA_OFS_CTL;
            s_d.busSize = 2'h2;
            s_d.st = ST_WBACK;
          end else begin
            s_d.remain = s_q.remain - 10'h001;
            s_d.burstLeft = s_q.burstLeft - 10'h001;
            s_d.busWrite = 1'b0;
            s_d.busAddr = s_q.srcAddr + stepOf(s_q.ctl[`MDCA_CW_SINC_HI:`MDCA_CW_SINC_LO]);
            s_d.busSize = s_q.ctl[`MDCA_CW_SSIZE_HI:`MDCA_CW_SSIZE_LO];
            s_d.st = ST_READ;
          end
        end
      end
      ST_WBACK: begin
        // control word stored, release the grant
        if (accepted) begin
          if (s_q.fin) begin
            s_d.doneIrq[s_q.grantCh] = 1'b1;
            s_d.chanEn[s_q.grantCh] = chanEnableSet[s_q.grantCh];
            s_d.autoRun[s_q.grantCh] = 1'b0;
          end
          s_d.fin = 1'b0;
          s_d.busWrite = 1'b0;
          s_d.grantValid = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
    endcase
    // software trigger set wins over its clear at grant
    s_d.swPend = s_d.swPend | swReq;
    // processor owns the bus, dma drops its request
    s_d.busReq = s_d.access && !cpuBusy;
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '{st: ST_IDLE, grantCh: 5'h00, busSize: 2'h0, remain: 10'h000,
               burstLeft: 10'h000, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign busReq = s_q.busReq;
  assign busWrite = s_q.busWrite;
  assign busAddr = s_q.busAddr;
  assign busWdata = s_q.busWdata;
  assign busSize = s_q.busSize;
  assign chanDone = s_q.doneIrq;
  assign chanEnabled = s_q.chanEn;
  assign chanPriority = s_q.prio;
  assign grantValid = s_q.grantValid;
  assign grantCh = s_q.grantCh;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // helper: items moved in the current grant
  logic [10:0] movedCnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || s_q.st == ST_IDLE) begin
      movedCnt <= 11'h000;
    end else if (s_q.st == ST_WRITE && accepted) begin
      movedCnt <= movedCnt + 11'h001;
    end
  end

  // no dma request while processor holds bus
  cpu_wins_a: assert property (cpuBusy |=> !busReq)
    else $error("dma requested bus while processor busy");

  // grant fixed for the whole burst
  grant_stable_a: assert property (grantValid && s_q.st != ST_IDLE |=> $stable(grantCh))
    else $error("grant changed during a burst");

  prio_level_a: assert property (s_q.st == ST_IDLE && |highPend |=> chanPriority[grantCh])
    else $error("default channel granted over high channel");

  lowest_idx_a: assert property (s_q.st == ST_IDLE && |pend && !(|highPend)
    |=> ($past(pend) & ((32'h00000001 << grantCh) - 32'h00000001)) == 32'h00000000)
    else $error("lower pending channel was passed over");

  // unmapped channels only start by software
  sw_only_a: assert property (s_q.st == ST_IDLE && |pend && !PERIPH_MAP[winner]
    |-> s_q.swPend[winner] || s_q.autoRun[winner])
    else $error("software channel granted without software request");

  single_one_a: assert property (s_q.st == ST_FCTL && accepted && !s_q.isBurst
    && cwMode == `MDCA_MODE_BASIC |=> s_q.burstLeft == 10'h000)
    else $error("single request set a longer burst");

  burst_cap_a: assert property (s_q.st == ST_WBACK |-> movedCnt <= {1'b0, s_q.ctl[`MDCA_CW_ARB_HI:`MDCA_CW_ARB_LO]} + 11'h001)
    else $error("burst moved more than its size");

  done_pulse_a: assert property (|chanDone |-> !grantValid ##1 chanDone == 32'h00000000)
    else $error("completion pulse malformed");

  mask_excl_a: assert property (s_q.st == ST_IDLE && |pend && s_q.reqMask[winner]
    |-> s_q.swPend[winner] || s_q.autoRun[winner])
    else $error("masked request was granted");

  // main scenarios
  burst_seen_c: cover property (s_q.st == ST_WRITE && accepted && s_q.burstLeft != 10'h000);
  stall_seen_c: cover property (s_q.access && cpuBusy ##1 busReq);
  done_seen_c: cover property (|chanDone);
  high_seen_c: cover property (s_q.st == ST_IDLE && |highPend && |(pend & ~s_q.prio));

endmodule
`default_nettype wire

// [sim/mdca_mem_model.sv]
// far-side bus and memory model for the dma channel arbiter
`timescale 1ns/1ps
`default_nettype none
module mdca_mem_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic cpuBusy,
  input wire logic [3:0] waitCycles,
  output logic busReady,
  output logic [31:0] busRdata
);
  // sparse memory with control table and data
  logic [31:0] mem [logic [31:0]];
  // wait counter for slow answers
  logic [3:0] cnt;
  // answers after waitCycles, holds ready until the access is taken
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      busReady <= 1'b0;
      busRdata <= 32'h5a5a5a5a;
      cnt <= 4'h0;
    end else if (busReq && busReady && !cpuBusy) begin
      if (busWrite) begin
        mem[busAddr] = busWdata;
      end
      busReady <= 1'b0;
      // stale read data scrambled
      busRdata <= ~busRdata;
      cnt <= 4'h0;
    end else if (busReq && cnt >= waitCycles) begin
      busReady <= 1'b1;
      busRdata <= mem.exists(busAddr) ? mem[busAddr] : 32'h0;
    end else if (busReq) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking testbench for the dma channel arbiter
`timescale 1ns/1ps
`default_nettype none
`include "mdca_cfg.svh"
module testbench;
  logic ref_clk, rst_n, cpuBusy, busReady, busReq, busWrite, grantValid, gvLast;
  logic [31:0] sReq, bReq, swReq, enSet, enClr, mSet, mClr, pSet, pClr, boSet, boClr;
  logic [31:0] busRdata, busAddr, busWdata, chanDone, chanEnabled, chanPriority;
  logic [31:0] doneSeen, items, accCnt;
  logic [1:0] busSize, wrSize, rdSize;
  logic [4:0] grantCh;
  logic [3:0] waitCycles;
  logic [31:0] order[$];
  logic [31:0] perGrant[$];
  int n_fail, checks, cycles;
  // control table on a 1024-byte boundary
  localparam logic [31:0] TBL = 32'h00010000;
  mdca_channel_arbiter dut (.ref_clk(ref_clk), .rst_n(rst_n), .periphSingleReq(sReq), .periphBurstReq(bReq),
    .swReq(swReq), .chanEnableSet(enSet), .chanEnableClear(enClr), .reqMaskSet(mSet), .reqMaskClear(mClr),
    .channelPrioritySetReg(pSet), .channelPriorityClearReg(pClr), .burstOnlySetReg(boSet),
    .burstOnlyClearReg(boClr), .tableBase(TBL[31:10]), .cpuBusy(cpuBusy), .busReady(busReady),
    .busRdata(busRdata), .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata),
    .busSize(busSize), .chanDone(chanDone), .chanEnabled(chanEnabled), .chanPriority(chanPriority),
    .grantValid(grantValid), .grantCh(grantCh));
  mdca_mem_model mdl (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .busWrite(busWrite),
    .busAddr(busAddr), .busWdata(busWdata), .cpuBusy(cpuBusy), .waitCycles(waitCycles),
    .busReady(busReady), .busRdata(busRdata));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // records grants, items per grant, completions; cuts a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
    if (rst_n) begin
      doneSeen = doneSeen | chanDone;
      if (busReq && busReady && !cpuBusy) accCnt++;
      // data traffic only, table excluded; last item sizes kept
      if (busReq && busReady && !cpuBusy && busAddr[31:16] != TBL[31:16]) begin
        if (busWrite) begin
          items++;
          wrSize = busSize;
        end else begin
          rdSize = busSize;
        end
      end
      if (grantValid && !gvLast) order.push_back({27'h0, grantCh});
      if (!grantValid && gvLast) begin
        perGrant.push_back(items);
        items = 0;
      end
      gvLast = grantValid;
    end
  end
  task automatic tick(int n);
    repeat (n) begin
      @(posedge ref_clk);
      #5;
    end
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // control word: word items, fixed addresses
  function automatic logic [31:0] cw(logic [9:0] arb, logic [9:0] cnt, logic [2:0] mode);
    return {`MDCA_INC_NONE, 2'h2, `MDCA_INC_NONE, 2'h2, arb, cnt, 1'b0, mode};
  endfunction
  // table entry plus source data of one channel
  task automatic setup(logic [4:0] ch, logic [31:0] ctl);
    logic [31:0] e;
    e = TBL | {23'h0, ch, 4'h0};
    mdl.mem[e] = 32'h1000 | {25'h0, ch, 2'h0};
    mdl.mem[e + 32'h4] = 32'h2000 | {25'h0, ch, 2'h0};
    mdl.mem[e + 32'h8] = ctl;
    mdl.mem[32'h1000 | {25'h0, ch, 2'h0}] = 32'hd0 + {27'h0, ch};
  endtask
  // bounded wait for completion pulses of all channels in m
  task automatic waitd(logic [31:0] m);
    for (int i = 0; i < 600 && (doneSeen & m) != m; i++) tick(1);
    chk("done", m, doneSeen & m);
    doneSeen = doneSeen & ~m;
  endtask
  task automatic t_strobe();
    chk("reset en", 0, chanEnabled);
    chk("reset grant", 0, {31'h0, grantValid});
    enSet = 32'h8;
    pSet = 32'h8;
    tick(1);
    enSet = 0;
    pClr = 32'h8;
    chk("enabled", 32'h8, chanEnabled);
    tick(1);
    pSet = 0;
    chk("prio both", 32'h8, chanPriority);
    tick(1);
    pClr = 0;
    enClr = 32'h8;
    chk("prio clr", 0, chanPriority);
    tick(1);
    enClr = 0;
    chk("disabled", 0, chanEnabled);
    $display("t_strobe done");
  endtask
  task automatic t_single();
    order.delete();
    perGrant.delete();
    setup(5'h08, cw(10'h3, 10'h1, `MDCA_MODE_BASIC));
    enSet = 32'h100;
    tick(1);
    enSet = 0;
    sReq = 32'h100;
    waitd(32'h100);
    sReq = 0;
    chk("items a", 1, perGrant[0]);
    chk("items b", 1, perGrant[1]);
    chk("grant", 8, order[1]);
    chk("data", 32'hd8, mdl.mem[32'h2020]);
    chk("ctl", cw(10'h3, 10'h0, `MDCA_MODE_STOP), mdl.mem[TBL + 32'h88]);
    chk("auto off", 0, chanEnabled);
    $display("t_single done");
  endtask
  task automatic t_prio();
    logic [4:0] chs[4] = '{5'd2, 5'd5, 5'd20, 5'd30};
    order.delete();
    foreach (chs[i]) setup(chs[i], cw(10'h0, 10'h0, `MDCA_MODE_BASIC));
    enSet = 32'h40100024;
    pSet = 32'h40100000;
    tick(1);
    enSet = 0;
    pSet = 0;
    swReq = 32'h40100024;
    tick(1);
    swReq = 0;
    waitd(32'h40100024);
    chk("first", 20, order[0]);
    chk("second", 30, order[1]);
    chk("third", 2, order[2]);
    chk("fourth", 5, order[3]);
    pClr = 32'h40100000;
    tick(1);
    pClr = 0;
    $display("t_prio done");
  endtask
  task automatic t_burst();
    logic [31:0] a;
    order.delete();
    perGrant.delete();
    waitCycles = 4'h2;
    setup(5'd24, cw(10'h1, 10'h2, `MDCA_MODE_BASIC));
    setup(5'd1, cw(10'h0, 10'h0, `MDCA_MODE_BASIC));
    enSet = 32'h01000002;
    tick(1);
    enSet = 0;
    sReq = 32'h01000000;
    bReq = 32'h01000000;
    for (int i = 0; i < 50 && grantValid !== 1'b1; i++) tick(1);
    bReq = 32'h01000002;
    cpuBusy = 1'b1;
    a = accCnt;
    tick(2);
    chk("yield", 0, {31'h0, busReq});
    tick(4);
    chk("stall", a, accCnt);
    cpuBusy = 1'b0;
    waitd(32'h01000002);
    sReq = 0;
    bReq = 0;
    waitCycles = 4'h0;
    chk("order a", 24, order[0]);
    chk("order b", 1, order[1]);
    chk("order c", 24, order[2]);
    chk("burst a", 2, perGrant[0]);
    chk("burst c", 1, perGrant[2]);
    $display("t_burst done");
  endtask
  task automatic t_mask();
    order.delete();
    perGrant.delete();
    setup(5'd10, cw(10'h1, 10'h1, `MDCA_MODE_BASIC));
    setup(5'd9, cw(10'h0, 10'h0, `MDCA_MODE_BASIC));
    setup(5'd6, cw(10'h0, 10'h0, `MDCA_MODE_BASIC));
    setup(5'd22, cw(10'h0, 10'h0, `MDCA_MODE_BASIC));
    enSet = 32'h640;
    boSet = 32'h400;
    mSet = 32'h200;
    tick(1);
    enSet = 0;
    boSet = 0;
    mSet = 0;
    sReq = 32'h00400640;
    tick(20);
    chk("ignored", 0, 32'(order.size()));
    swReq = 32'h200;
    tick(1);
    swReq = 0;
    waitd(32'h200);
    bReq = 32'h400;
    waitd(32'h400);
    chk("burst only", 2, perGrant[1]);
    chk("unmapped", 32'h40, chanEnabled);
    sReq = 0;
    bReq = 0;
    enClr = 32'h40;
    boClr = 32'h400;
    mClr = 32'h200;
    tick(1);
    enClr = 0;
    boClr = 0;
    mClr = 0;
    $display("t_mask done");
  endtask
  // stop-mode word, then auto mode with stepping addresses and mixed sizes
  task automatic t_auto();
    logic [31:0] ac;
    // dst half step and size, src word step byte size, burst 2, three items
    ac = {2'h1, 2'h1, 2'h2, 2'h0, 10'h1, 10'h2, 1'b0, `MDCA_MODE_AUTO};
    order.delete();
    setup(5'd31, cw(10'h0, 10'h0, `MDCA_MODE_STOP));
    enSet = 32'h80000000;
    tick(1);
    enSet = 0;
    swReq = 32'h80000000;
    tick(1);
    swReq = 0;
    tick(20);
    chk("stop grant", 31, order[0]);
    chk("stop off", 0, chanEnabled);
    chk("stop quiet", 0, doneSeen & 32'h80000000);
    order.delete();
    perGrant.delete();
    setup(5'd30, ac);
    mdl.mem[32'h1070] = 32'hc1;
    mdl.mem[32'h1074] = 32'hc2;
    mdl.mem[32'h2078] = 32'h0;
    enSet = 32'h40000000;
    tick(1);
    enSet = 0;
    swReq = 32'h40000000;
    tick(1);
    swReq = 0;
    waitd(32'h40000000);
    chk("auto first", 30, order[0]);
    chk("auto again", 30, order[1]);
    chk("auto burst", 2, perGrant[0]);
    chk("auto rest", 1, perGrant[1]);
    chk("dst 0", 32'hc1, mdl.mem[32'h2074]);
    chk("dst 1", 32'hc2, mdl.mem[32'h2076]);
    chk("dst 2", 32'hee, mdl.mem[32'h2078]);
    chk("wr size", 1, {30'h0, wrSize});
    chk("rd size", 0, {30'h0, rdSize});
    chk("auto ctl", {ac[31:14], 10'h000, 1'b0, `MDCA_MODE_STOP}, mdl.mem[TBL + 32'h1e8]);
    $display("t_auto done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // reset, then scenarios in order
  initial begin
    {sReq, bReq, swReq, enSet, enClr, mSet, mClr, pSet, pClr, boSet, boClr} = '0;
    {cpuBusy, gvLast, doneSeen, items, accCnt, waitCycles, wrSize, rdSize} = '0;
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    tick(1);
    t_strobe();
    t_single();
    t_prio();
    t_burst();
    t_mask();
    t_auto();
    summarize();
  end
endmodule
`default_nettype wire
